// File: pkg/mls_spi_target_regs.vh
// constants for the multi-lane spi target with crc checking
`ifndef MLS_SPI_TARGET_REGS_VH
`define MLS_SPI_TARGET_REGS_VH

`define MLS_CRC_SEED      8'ha5
`define MLS_CRC_POLY      8'h07
`define MLS_CRC_CFG_ADDR  7'h10
`define MLS_STATUS_ADDR   7'h11
`define MLS_STATUS_CRC    3
`define MLS_CRC_EN_ON     2'b01
`define MLS_CRC_EN_OFF    2'b00
`define MLS_LANE_DUAL     2'b01
`define MLS_CRC_EN_LSB    0
`define MLS_CRC_ENB_LSB   2

`endif

// File: design/mls_spi_target.v
// multi-lane spi target with crc checking of register transactions
`timescale 1ns/1ps
`default_nettype none
`include "mls_spi_target_regs.vh"

module mls_spi_target
(
	input  wire        i_core_clk,
	input  wire        i_resetn,
	input  wire        i_cs_n,
	input  wire        i_sclk,
	input  wire [3:0]  i_lane_in,
	output reg  [3:0]  o_lane_out,
	output reg  [3:0]  o_lane_oe,
	input  wire        i_quad_strap,
	input  wire [1:0]  i_lane_mode,
	input  wire        i_ddr,
	input  wire        i_single_instr,
	input  wire        i_addr_ascend,
	input  wire [1:0]  i_reg_len,
	input  wire [31:0] i_rd_data,
	output reg  [6:0]  o_addr,
	output reg         o_wr,
	output reg  [6:0]  o_wr_addr,
	output reg  [31:0] o_wr_data,
	output reg  [1:0]  o_wr_len,
	output reg         o_crc_on,
	output reg         o_crc_fail,
	output reg         o_quad
);

	// ****************************************************************
	// state codes
	// ****************************************************************
	localparam [1:0] ST_INSTR = 2'd0;
	localparam [1:0] ST_DATA  = 2'd1;
	localparam [1:0] ST_CRC   = 2'd2;

	// msb first, no reflection, no final inversion
	function [7:0] crc8;
		input [7:0] crc;
		input [7:0] din;
		integer     k;
		reg     [7:0] c;
		begin
			c = crc ^ din;
			for (k = 0; k < 8; k = k + 1)
				c = c[7] ? ({c[6:0], 1'b0} ^ `MLS_CRC_POLY) : {c[6:0], 1'b0};
			crc8 = c;
		end
	endfunction

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	reg [2:0] cs_s_q;
	reg [2:0] sck_s_q;
	reg [3:0] ln0_q;
	reg [3:0] ln1_q;
	reg       strap0_q;
	reg       strap1_q;

	always @(posedge i_core_clk or negedge i_resetn)
		if (!i_resetn)
		begin
			cs_s_q   <= 3'h7;
			sck_s_q  <= 3'h0;
			ln0_q    <= 4'h0;
			ln1_q    <= 4'h0;
			strap0_q <= 1'b0;
			strap1_q <= 1'b0;
		end
		else
		begin
			cs_s_q   <= {cs_s_q[1:0], i_cs_n};
			sck_s_q  <= {sck_s_q[1:0], i_sclk};
			ln0_q    <= i_lane_in;
			ln1_q    <= ln0_q;
			strap0_q <= i_quad_strap;
			strap1_q <= strap0_q;
		end

	wire sck_rise = sck_s_q[1] & ~sck_s_q[2];
	wire sck_fall = ~sck_s_q[1] & sck_s_q[2];
	wire cs_act   = ~cs_s_q[1];
	wire cs_start = cs_s_q[2] & ~cs_s_q[1];
	wire cs_end   = ~cs_s_q[2] & cs_s_q[1];

	// ****************************************************************
	// frame state
	// ****************************************************************
	reg [1:0]  st_q;
	reg [1:0]  wm_q;
	reg        ddr_q;
	reg        rd_q;
	reg [3:0]  bcnt_q;
	reg [7:0]  rx_q;
	reg [1:0]  bidx_q;
	reg [1:0]  len_q;
	reg        ld_q;
	reg [31:0] wbuf_q;
	reg [31:0] rbuf_q;
	reg [7:0]  crc_q;
	reg        crc_pend_q;
	reg        crc_pend_v_q;
	reg [7:0]  tx_q;
	reg [2:0]  tcnt_q;
	reg [1:0]  stcnt_q;

	wire [3:0] nlanes = (wm_q == 2'd0) ? 4'd1 : (wm_q == 2'd1) ? 4'd2 : 4'd4;
	wire [3:0] bnext  = bcnt_q + nlanes;
	wire       byte_done = (bnext == 4'd8);

	// double rate only on write data and its crc byte
	wire ddr_on = ddr_q & ~rd_q & (st_q != ST_INSTR);
	wire samp   = cs_act & (sck_rise | (sck_fall & ddr_on));

	reg [7:0] rxn;
	always @*
	begin
		case (wm_q)
		2'd0:    rxn = {rx_q[6:0], ln1_q[0]};
		2'd1:    rxn = {rx_q[5:0], ln1_q[1:0]};
		default: rxn = {rx_q[3:0], ln1_q[3:0]};
		endcase
	end

	wire [7:0] rbyte = rbuf_q[{bidx_q, 3'b000} +: 8];

	reg [31:0] wnext;
	always @*
	begin
		wnext = wbuf_q;
		wnext[{bidx_q, 3'b000} +: 8] = rxn;
	end

	wire       last_b  = (bidx_q == len_q);
	wire       in_data = samp & byte_done & (st_q == ST_DATA);
	wire       in_crc  = samp & byte_done & (st_q == ST_CRC);
	// crc follows the whole register, not each byte
	wire       to_crc  = in_data & last_b & o_crc_on;
	wire       crc_ok  = (rxn == crc_q);
	wire       wr_now  = (in_data & last_b & ~o_crc_on & ~rd_q) |
	                     (in_crc & ~rd_q & crc_ok);
	wire       unit_end = (in_data & last_b & ~o_crc_on) | in_crc;
	wire [6:0] step    = {5'h0, len_q} + 7'd1;
	wire [6:0] addr_nx = i_addr_ascend ? (o_addr + step) : (o_addr - step);
	wire       miss    = cs_end & o_crc_on & ~rd_q &
	                     ((st_q == ST_CRC) |
	                      ((st_q == ST_DATA) & ((bidx_q != 2'd0) | (bcnt_q != 4'd0))));
	wire       set_fail = (in_crc & ~rd_q & ~crc_ok) | miss;
	wire       clr_fail = o_wr & (o_wr_addr == `MLS_STATUS_ADDR) &
	                      o_wr_data[`MLS_STATUS_CRC];
	wire [1:0] en_f  = o_wr_data[`MLS_CRC_EN_LSB +: 2];
	wire [1:0] enb_f = o_wr_data[`MLS_CRC_ENB_LSB +: 2];
	wire       cfg_wr = o_wr & (o_wr_addr == `MLS_CRC_CFG_ADDR) &
	                    (enb_f == ~en_f) &
	                    ((en_f == `MLS_CRC_EN_ON) | (en_f == `MLS_CRC_EN_OFF));

	// ****************************************************************
	// receive, crc and framing
	// ****************************************************************
	always @(posedge i_core_clk or negedge i_resetn)
		if (!i_resetn)
		begin
			st_q         <= ST_INSTR;
			wm_q         <= 2'd0;
			ddr_q        <= 1'b0;
			rd_q         <= 1'b0;
			bcnt_q       <= 4'h0;
			rx_q         <= 8'h00;
			bidx_q       <= 2'd0;
			len_q        <= 2'd0;
			ld_q         <= 1'b0;
			wbuf_q       <= 32'h0;
			rbuf_q       <= 32'h0;
			crc_q        <= 8'h00;
			crc_pend_q   <= 1'b0;
			crc_pend_v_q <= 1'b0;
			stcnt_q      <= 2'd0;
			o_addr       <= 7'h00;
			o_wr         <= 1'b0;
			o_wr_addr    <= 7'h00;
			o_wr_data    <= 32'h0;
			o_wr_len     <= 2'd0;
			o_crc_on     <= 1'b0;
			o_crc_fail   <= 1'b0;
			o_quad       <= 1'b0;
		end
		else
		begin
			// strap follows its pin for a few cycles after release
			if (stcnt_q != 2'd3)
			begin
				stcnt_q <= stcnt_q + 2'd1;
				o_quad  <= strap1_q;
			end
			o_wr       <= wr_now;
			o_crc_fail <= set_fail | (o_crc_fail & ~clr_fail);
			ld_q       <= 1'b0;
			if (ld_q)
			begin
				len_q  <= i_reg_len;
				rbuf_q <= i_rd_data;
			end
			if (wr_now)
			begin
				o_wr_addr <= o_addr;
				o_wr_data <= (st_q == ST_CRC) ? wbuf_q : wnext;
				o_wr_len  <= len_q;
			end
			if (cfg_wr)
			begin
				crc_pend_q   <= (en_f == `MLS_CRC_EN_ON);
				crc_pend_v_q <= 1'b1;
			end
			if (cs_start)
			begin
				// lane mode and rate fixed for the whole frame
				wm_q   <= o_quad ? 2'd2 :
				          (i_lane_mode == `MLS_LANE_DUAL) ? 2'd1 : 2'd0;
				ddr_q  <= i_ddr;
				st_q   <= ST_INSTR;
				bcnt_q <= 4'h0;
			end
			else if (cs_end)
			begin
				st_q   <= ST_INSTR;
				bcnt_q <= 4'h0;
				if (crc_pend_v_q)
				begin
					o_crc_on     <= crc_pend_q;
					crc_pend_v_q <= 1'b0;
				end
			end
			else if (samp)
			begin
				rx_q   <= rxn;
				bcnt_q <= byte_done ? 4'h0 : bnext;
				if (byte_done)
				begin
					case (st_q)
					ST_INSTR:
					begin
						rd_q   <= rxn[7];
						o_addr <= rxn[6:0];
						crc_q  <= crc8(`MLS_CRC_SEED, rxn);
						st_q   <= ST_DATA;
						bidx_q <= 2'd0;
						ld_q   <= 1'b1;
					end
					ST_DATA:
					begin
						if (rd_q)
							crc_q <= crc8(crc_q, rbyte);
						else
						begin
							crc_q  <= crc8(crc_q, rxn);
							wbuf_q <= wnext;
						end
						bidx_q <= bidx_q + 2'd1;
						if (to_crc)
							st_q <= ST_CRC;
					end
					default:
						st_q <= ST_DATA;
					endcase
					if (unit_end)
					begin
						bidx_q <= 2'd0;
						if (i_single_instr)
							st_q <= ST_INSTR;
						else
						begin
							st_q   <= ST_DATA;
							o_addr <= addr_nx;
							crc_q  <= {1'b0, addr_nx};
							ld_q   <= 1'b1;
						end
					end
				end
			end
		end

	// ****************************************************************
	// transmit on falling clock edges, always single rate
	// ****************************************************************
	wire tx_en = cs_act & sck_fall &
	             (((st_q == ST_DATA) & rd_q) |
	              ((st_q == ST_CRC) & (rd_q | (wm_q == 2'd0))));
	wire [7:0] tx_src = (st_q == ST_CRC) ? crc_q : rbyte;
	wire [7:0] tx_cur = (tcnt_q == 3'd0) ? tx_src : tx_q;
	wire [3:0] oe_dir = (wm_q == 2'd0) ? 4'b0010 :
	                    (~rd_q | (st_q == ST_INSTR)) ? 4'b0000 :
	                    (wm_q == 2'd1) ? 4'b0011 : 4'b1111;

	always @(posedge i_core_clk or negedge i_resetn)
		if (!i_resetn)
		begin
			tx_q       <= 8'h00;
			tcnt_q     <= 3'd0;
			o_lane_out <= 4'h0;
			o_lane_oe  <= 4'h0;
		end
		else
		begin
			o_lane_oe <= cs_act ? oe_dir : 4'h0;
			if (!cs_act)
			begin
				tcnt_q     <= 3'd0;
				o_lane_out <= 4'h0;
			end
			else if (samp & byte_done & (st_q == ST_INSTR))
				tcnt_q <= 3'd0;
			else if (tx_en)
			begin
				tx_q   <= tx_cur << nlanes[2:0];
				tcnt_q <= tcnt_q + nlanes[2:0];
				case (wm_q)
				2'd0:    o_lane_out <= {2'b00, tx_cur[7], 1'b0};
				2'd1:    o_lane_out <= {2'b00, tx_cur[7:6]};
				default: o_lane_out <= tx_cur[7:4];
				endcase
			end
		end

endmodule

`default_nettype wire

// File: test/mls_spi_host.sv
// single-lane host controller model on the target's link
`timescale 1ns/1ps
`default_nettype none
module mls_spi_host
(
	input  wire logic       i_core_clk,
	input  wire logic [3:0] i_dev_out,
	input  wire logic [3:0] i_dev_oe,
	output var logic        o_cs_n,
	output var logic        o_sclk,
	output wire logic [3:0] o_lane
);
	logic d = 1'b0;
	// driven lanes show the device, undriven lane zero host data, the other undriven lanes its inverse
	assign o_lane = (i_dev_oe & i_dev_out) | (~i_dev_oe & {~d, ~d, ~d, d});
	initial o_cs_n = 1'b1;
	initial o_sclk = 1'b0;
	task tick(input integer n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask
	task open();
		tick(1);
		o_cs_n = 1'b0;
	endtask
	// mode 0 at single rate: set on the fall, sampled at the rise
	task xfer(input logic [7:0] tx, output logic [7:0] rx);
		integer i;
		for (i = 7; i >= 0; i = i - 1)
		begin
			tick(4);
			o_sclk = 1'b0;
			d = tx[i];
			tick(4);
			rx[i] = i_dev_out[1];
			o_sclk = 1'b1;
		end
	endtask
	// deselect after every access; released line shows inverse
	task close();
		tick(4);
		o_sclk = 1'b0;
		tick(4);
		o_cs_n = 1'b1;
		d = ~d;
		tick(8);
	endtask
endmodule
`default_nettype wire

// File: test/mls_spi_target_chk.sv
// port assertions for the multi-lane spi target
`timescale 1ns/1ps
`default_nettype none
`include "mls_spi_target_regs.vh"
module mls_spi_target_chk
(
	input wire logic        i_core_clk,
	input wire logic        i_resetn,
	input wire logic        i_cs_n,
	input wire logic        i_sclk,
	input wire logic [3:0]  o_lane_out,
	input wire logic [3:0]  o_lane_oe,
	input wire logic        o_wr,
	input wire logic [6:0]  o_wr_addr,
	input wire logic [31:0] o_wr_data,
	input wire logic        o_crc_on,
	input wire logic        o_crc_fail
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	property p_wr_pulse; o_wr |=> !o_wr; endproperty
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("write pulse too long");
	property p_idle; i_cs_n[*5] |-> o_lane_oe == 4'h0; endproperty
	a_idle: assert property (p_idle)
		else $error("lane driven while deselected");
	// lane one is a plain output in single-lane mode, the rest are inputs
	property p_instr;
		i_cs_n[*5] ##1 !i_cs_n |-> ((o_lane_oe & 4'b1101) == 4'h0)[*8];
	endproperty
	a_instr: assert property (p_instr)
		else $error("lane driven in instruction");
	property p_set; $rose(o_crc_fail) |-> $past(o_crc_on) && !o_wr; endproperty
	a_set: assert property (p_set)
		else $error("flag set with write kept");
	property p_clr;
		$fell(o_crc_fail) |-> $past(o_wr) && o_wr_addr == `MLS_STATUS_ADDR
			&& o_wr_data[`MLS_STATUS_CRC];
	endproperty
	a_clr: assert property (p_clr)
		else $error("flag cleared without write");
	property p_on;
		$rose(o_crc_on) |-> i_cs_n && o_wr_addr == `MLS_CRC_CFG_ADDR
			&& o_wr_data[3:0] == 4'h9;
	endproperty
	a_on: assert property (p_on)
		else $error("crc on without enable pair");
	property p_off;
		$fell(o_crc_on) |-> i_cs_n && o_wr_addr == `MLS_CRC_CFG_ADDR
			&& o_wr_data[3:0] == 4'hc;
	endproperty
	a_off: assert property (p_off)
		else $error("crc off without disable pair");
	property p_fall;
		$changed(o_lane_out) && !$past(i_cs_n, 4) |-> !$past(i_sclk, 2);
	endproperty
	a_fall: assert property (p_fall)
		else $error("output moved off a falling edge");
endmodule
bind mls_spi_target mls_spi_target_chk u_chk (.i_core_clk(i_core_clk),
	.i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_sclk(i_sclk),
	.o_lane_out(o_lane_out), .o_lane_oe(o_lane_oe), .o_wr(o_wr),
	.o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_crc_on(o_crc_on),
	.o_crc_fail(o_crc_fail));
`default_nettype wire

// File: test/tb_mls_spi_target.sv
// self-checking bench for the multi-lane spi target
`timescale 1ns/1ps
`default_nettype none
`include "mls_spi_target_regs.vh"
module tb_mls_spi_target;
	logic        clk = 0;
	logic        rstn = 0;
	logic        cs, sclk, wr, crc_on, fail, quad;
	logic [3:0]  lane, lout, loe;
	logic [1:0]  len = 0, wlen;
	logic [6:0]  addr, waddr;
	logic [31:0] rd = 0, wdat, rxd, m;
	logic [7:0]  rxc, c;
	logic [41:0] rows [0:4];
	logic        si = 1'b1, asc = 1'b1;
	integer      n_fail = 0, checks = 0, nwr = 0, k, n;
	always #25 clk = ~clk;
	always @(posedge clk) if (wr === 1'b1) nwr <= nwr + 1;
	mls_spi_target u_dut (.i_core_clk(clk), .i_resetn(rstn), .i_cs_n(cs),
		.i_sclk(sclk), .i_lane_in(lane), .o_lane_out(lout), .o_lane_oe(loe),
		.i_quad_strap(1'b0), .i_lane_mode(2'b00), .i_ddr(1'b0),
		.i_single_instr(si), .i_addr_ascend(asc), .i_reg_len(len),
		.i_rd_data(rd), .o_addr(addr), .o_wr(wr), .o_wr_addr(waddr),
		.o_wr_data(wdat), .o_wr_len(wlen), .o_crc_on(crc_on),
		.o_crc_fail(fail), .o_quad(quad));
	mls_spi_host u_host (.i_core_clk(clk), .i_dev_out(lout), .i_dev_oe(loe),
		.o_cs_n(cs), .o_sclk(sclk), .o_lane(lane));
	task chk(input string nm, input logic [63:0] s, input logic [63:0] e);
		checks = checks + 1;
		if (s !== e)
		begin
			n_fail = n_fail + 1;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic [7:0] crc(input [7:0] r, input [7:0] b);
		integer i;
		r = r ^ b;
		for (i = 0; i < 8; i = i + 1)
			r = {r[6:0], 1'b0} ^ (r[7] ? `MLS_CRC_POLY : 8'h00);
		return r;
	endfunction
	function automatic [7:0] crc_of(input [7:0] ins, input [1:0] ln,
		input [31:0] d);
		integer j;
		crc_of = crc(`MLS_CRC_SEED, ins);
		for (j = 0; j <= ln; j = j + 1)
			crc_of = crc(crc_of, d[8*j+:8]);
	endfunction
	task frame(input [7:0] ins, input [1:0] ln, input [31:0] wd,
		input logic sc, input [7:0] cx);
		logic [7:0] b;
		integer j;
		len = ln;
		u_host.open();
		u_host.xfer(ins, b);
		for (j = 0; j <= ln; j = j + 1)
		begin
			u_host.xfer(wd[8*j+:8], b);
			rxd[8*j+:8] = b;
		end
		if (sc)
			u_host.xfer(cx, rxc);
		u_host.close();
	endtask
	task finish_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail = n_fail + 1;
		finish_test();
	end
	initial
	begin
		rows[0] = {8'h05, 2'd0, 32'h3c};
		rows[1] = {8'h06, 2'd1, 32'hbeef};
		rows[2] = {8'h87, 2'd0, 32'h5a};
		rows[3] = {8'h88, 2'd3, 32'h89abcdef};
		rows[4] = {1'b0, `MLS_CRC_CFG_ADDR, 2'd0, 32'h5};
		repeat (6) @(posedge clk);
		#1 rstn = 1;
		u_host.tick(8);
		chk("reset", {quad, crc_on, fail, wr, loe}, 0);
		for (k = 0; k < 5; k = k + 1)
		begin
			n = nwr;
			rd = rows[k][31:0];
			frame(rows[k][41:34], rows[k][33:32], rows[k][31:0], 0, 0);
			m = ~(32'hffffffff << 8 * (rows[k][33:32] + 1));
			if (rows[k][41])
				chk("rx", {addr, rxd & m},
					{rows[k][40:34], rd & m});
			else
				chk("wr", {waddr, wlen, wdat & m},
					rows[k][40:0] & {9'h1ff, m});
			chk("count", nwr - n, !rows[k][41]);
		end
		chk("crc_on", crc_on, 0);
		frame({1'b0, `MLS_CRC_CFG_ADDR}, 0, 32'h9, 0, 0);
		chk("crc_on", crc_on, 1);
		// two-byte register, one crc after its last byte
		n = nwr;
		c = crc_of(8'h06, 1, 32'h1234);
		frame(8'h06, 1, 32'h1234, 1, c);
		chk("dev crc", rxc, c);
		chk("wr", {nwr - n, wdat[15:0]}, {32'd1, 16'h1234});
		// missing crc, then a clear with a wrong crc
		frame(8'h05, 0, 32'h77, 0, 0);
		c = crc_of({1'b0, `MLS_STATUS_ADDR}, 0, 32'h8);
		frame({1'b0, `MLS_STATUS_ADDR}, 0, 32'h8, 1, ~c);
		chk("refused", {nwr - n, fail}, {32'd1, 1'b1});
		frame({1'b0, `MLS_STATUS_ADDR}, 0, 32'h8, 1, c);
		chk("cleared", {nwr - n, fail}, {32'd2, 1'b0});
		rd = 32'ha7;
		frame(8'h87, 0, 0, 1, crc_of(8'h87, 0, 0));
		chk("rd crc", {rxd[7:0], rxc},
			{8'ha7, crc_of(8'h87, 0, rd)});
		c = crc_of({1'b0, `MLS_CRC_CFG_ADDR}, 0, 32'hc);
		frame({1'b0, `MLS_CRC_CFG_ADDR}, 0, 32'hc, 1, c);
		chk("crc_on", crc_on, 0);
		n = nwr;
		frame(8'h05, 0, 32'h42, 0, 0);
		chk("plain", {nwr - n, wdat[7:0]}, {32'd1, 8'h42});
		// streaming, descending then ascending, one byte per register
		si = 1'b0;
		len = 2'd0;
		for (k = 0; k < 2; k = k + 1)
		begin
			asc = k[0];
			n = nwr;
			u_host.open();
			u_host.xfer(8'h05, c);
			u_host.xfer(8'h11, c);
			u_host.xfer(8'h22, c);
			u_host.close();
			chk("stream", {nwr - n, waddr, wdat[7:0], addr},
				{32'd2, (k ? 7'h06 : 7'h04), 8'h22,
				(k ? 7'h07 : 7'h03)});
		end
		// reset in mid-run clears the stepped address
		rstn = 1'b0;
		u_host.tick(2);
		rstn = 1'b1;
		u_host.tick(8);
		chk("re-reset", {quad, addr, crc_on, fail, wr, loe}, 0);
		finish_test();
	end
endmodule
`default_nettype wire
